// ===== scsc_clock_ctrl.sv
// AHB-Lite register file and clock selection for the main system clock.
`timescale 1ns/1ps
`include "scsc_defs.svh"

module scsc_clock_ctrl
	import scsc_pkg::*;
#(
	parameter int SETTLE_CYC = `SCSC_IOSC_SETTLE_CYC
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        iosc_clk,
	input  wire logic        highspeed_sys_clock,
	input  wire logic        wakeup,
	input  wire logic        cpu_low_status,
	output logic             xtal_osc_enable,
	output logic             ext_clk_enable,
	output logic             crystal_pin_a_port_en,
	output logic             crystal_pin_b_port_en,
	output logic             iosc_enable,
	output logic             stop_mode,
	output logic      [2:0]  stabilization_time_select,
	output logic             main_clk,
	output logic             periph_clk,
	output logic             cpu_clk
);
	localparam int CNT_W = $clog2(SETTLE_CYC + 1);

	if (SETTLE_CYC < 1) begin : g_settle_check
		$error("SETTLE_CYC must be at least 1");
	end

	function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
		addr_is = (a[11:2] == ofs[11:2]);
	endfunction : addr_is

	// ----------------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------------
	logic             ext_input_select_r;
	logic             ext_input_select_nxt;
	logic             pin_function_select_r;
	logic             pin_function_select_nxt;
	logic             highspeed_stop_r;
	logic             highspeed_stop_nxt;
	logic             source_select_r;
	logic             source_select_nxt;
	logic             main_select_r;
	logic             main_select_nxt;
	logic [2:0]       cpu_div_r;
	logic [2:0]       cpu_div_nxt;
	logic             internal_osc_stop_r;
	logic             internal_osc_stop_nxt;
	logic [2:0]       stab_sel_r;
	logic [2:0]       stab_sel_nxt;
	logic             stop_mode_r;
	logic             stop_mode_nxt;
	logic [CNT_W-1:0] settle_cnt_r;
	logic [CNT_W-1:0] settle_cnt_nxt;
	logic             internal_osc_settled_r;
	logic             internal_osc_settled_nxt;
	logic             wr_pend_r;
	logic             wr_pend_nxt;
	logic [11:0]      wr_addr_r;
	logic [11:0]      wr_addr_nxt;
	logic [31:0]      hrdata_r;
	logic [31:0]      hrdata_nxt;
	logic             cpu_source_status_r;
	logic             cpu_source_status_nxt;
	logic             src_s1_r;
	scsc_pin_mode_e   pin_mode;
	logic             req;
	logic [31:0]      rd_word;

	assign req = hsel && hready && htrans[1];

	// ----------------------------------------------------------------------
	// Pin mode decode
	// ----------------------------------------------------------------------
	always_comb begin
		pin_mode = SCSC_PINS_PORT;
		if (pin_function_select_r) begin
			pin_mode = ext_input_select_r ? SCSC_PINS_EXTIN : SCSC_PINS_XTAL;
		end
	end

	assign crystal_pin_a_port_en = (pin_mode != SCSC_PINS_XTAL);
	assign crystal_pin_b_port_en = (pin_mode == SCSC_PINS_PORT);
	assign xtal_osc_enable = (pin_mode == SCSC_PINS_XTAL) && !highspeed_stop_r
		&& !stop_mode_r;
	assign ext_clk_enable = (pin_mode == SCSC_PINS_EXTIN) && !highspeed_stop_r
		&& !stop_mode_r;
	assign iosc_enable = !internal_osc_stop_r && !stop_mode_r;
	assign stop_mode = stop_mode_r;
	assign stabilization_time_select = stab_sel_r;

	// ----------------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------------
	always_comb begin
		rd_word = 32'h0000_0000;
		if (addr_is(haddr, `SCSC_PIN_MODE_OFS)) begin
			rd_word[`SCSC_EXT_SEL_BIT]  = ext_input_select_r;
			rd_word[`SCSC_PIN_FUNC_BIT] = pin_function_select_r;
		end else if (addr_is(haddr, `SCSC_HS_OSC_OFS)) begin
			rd_word[`SCSC_HS_STOP_BIT] = highspeed_stop_r;
		end else if (addr_is(haddr, `SCSC_MAIN_SEL_OFS)) begin
			rd_word[`SCSC_SRC_SEL_BIT]  = source_select_r;
			rd_word[`SCSC_SRC_STAT_BIT] = cpu_source_status_r;
			rd_word[`SCSC_MAIN_SEL_BIT] = main_select_r;
		end else if (addr_is(haddr, `SCSC_CPU_DIV_OFS)) begin
			rd_word[`SCSC_LOW_STAT_BIT] = cpu_low_status;
			rd_word[2:0] = cpu_div_r;
		end else if (addr_is(haddr, `SCSC_INT_OSC_OFS)) begin
			rd_word[`SCSC_IOSC_OK_BIT]   = internal_osc_settled_r;
			rd_word[`SCSC_IOSC_STOP_BIT] = internal_osc_stop_r;
		end else if (addr_is(haddr, `SCSC_STAB_OFS)) begin
			rd_word[2:0] = stab_sel_r;
		end else if (addr_is(haddr, `SCSC_STANDBY_OFS)) begin
			rd_word[`SCSC_STOP_CMD_BIT] = stop_mode_r;
		end
	end

	// ----------------------------------------------------------------------
	// Next-state logic for the bus and control registers
	// ----------------------------------------------------------------------
	always_comb begin
		ext_input_select_nxt     = ext_input_select_r;
		pin_function_select_nxt  = pin_function_select_r;
		highspeed_stop_nxt       = highspeed_stop_r;
		source_select_nxt        = source_select_r;
		main_select_nxt          = main_select_r;
		cpu_div_nxt              = cpu_div_r;
		internal_osc_stop_nxt    = internal_osc_stop_r;
		stab_sel_nxt             = stab_sel_r;
		stop_mode_nxt            = stop_mode_r;
		settle_cnt_nxt           = settle_cnt_r;
		internal_osc_settled_nxt = internal_osc_settled_r;
		wr_pend_nxt              = req && hwrite;
		wr_addr_nxt              = req ? haddr : wr_addr_r;
		hrdata_nxt               = (req && !hwrite) ? rd_word : hrdata_r;
		cpu_source_status_nxt    = src_s1_r;
		if (wr_pend_r) begin
			if (addr_is(wr_addr_r, `SCSC_PIN_MODE_OFS)) begin
				ext_input_select_nxt    = hwdata[`SCSC_EXT_SEL_BIT];
				pin_function_select_nxt = hwdata[`SCSC_PIN_FUNC_BIT];
			end
			if (addr_is(wr_addr_r, `SCSC_HS_OSC_OFS)) begin
				highspeed_stop_nxt = hwdata[`SCSC_HS_STOP_BIT];
			end
			if (addr_is(wr_addr_r, `SCSC_MAIN_SEL_OFS)) begin
				source_select_nxt = hwdata[`SCSC_SRC_SEL_BIT];
				main_select_nxt   = hwdata[`SCSC_MAIN_SEL_BIT];
			end
			if (addr_is(wr_addr_r, `SCSC_CPU_DIV_OFS) && hwdata[2:0] <= `SCSC_CPU_DIV_MAX) begin
				cpu_div_nxt = hwdata[2:0];
			end
			if (addr_is(wr_addr_r, `SCSC_INT_OSC_OFS)) begin
				internal_osc_stop_nxt = hwdata[`SCSC_IOSC_STOP_BIT];
			end
			if (addr_is(wr_addr_r, `SCSC_STAB_OFS)) begin
				stab_sel_nxt = hwdata[2:0];
			end
			if (addr_is(wr_addr_r, `SCSC_STANDBY_OFS) && hwdata[`SCSC_STOP_CMD_BIT]) begin
				stop_mode_nxt = 1'b1;
			end
		end
		if (wakeup) begin
			stop_mode_nxt = 1'b0;
		end
		if (!iosc_enable) begin
			settle_cnt_nxt           = '0;
			internal_osc_settled_nxt = 1'b0;
		end else if (settle_cnt_r == CNT_W'(SETTLE_CYC)) begin
			internal_osc_settled_nxt = 1'b1;
		end else begin
			settle_cnt_nxt = settle_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_input_select_r     <= 1'b0;
			pin_function_select_r  <= 1'b0;
			highspeed_stop_r       <= 1'b1;
			source_select_r        <= 1'b0;
			main_select_r          <= 1'b0;
			cpu_div_r              <= `SCSC_CPU_DIV_RST;
			internal_osc_stop_r    <= 1'b0;
			stab_sel_r             <= `SCSC_STAB_SEL_RST;
			stop_mode_r            <= 1'b0;
			settle_cnt_r           <= '0;
			internal_osc_settled_r <= 1'b0;
			wr_pend_r              <= 1'b0;
			wr_addr_r              <= 12'h000;
			hrdata_r               <= 32'h0000_0000;
			cpu_source_status_r    <= 1'b0;
			src_s1_r               <= 1'b0;
		end else begin
			ext_input_select_r     <= ext_input_select_nxt;
			pin_function_select_r  <= pin_function_select_nxt;
			highspeed_stop_r       <= highspeed_stop_nxt;
			source_select_r        <= source_select_nxt;
			main_select_r          <= main_select_nxt;
			cpu_div_r              <= cpu_div_nxt;
			internal_osc_stop_r    <= internal_osc_stop_nxt;
			stab_sel_r             <= stab_sel_nxt;
			stop_mode_r            <= stop_mode_nxt;
			settle_cnt_r           <= settle_cnt_nxt;
			internal_osc_settled_r <= internal_osc_settled_nxt;
			wr_pend_r              <= wr_pend_nxt;
			wr_addr_r              <= wr_addr_nxt;
			hrdata_r               <= hrdata_nxt;
			src_s1_r               <= source_select_r && main_select_r;
			cpu_source_status_r    <= cpu_source_status_nxt;
		end
	end

	assign hrdata    = hrdata_r;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ----------------------------------------------------------------------
	// Clock trees
	// ----------------------------------------------------------------------
	scsc_clk_mux u_main_mux (
		.hresetn (hresetn),
		.clk_a   (iosc_clk),
		.clk_b   (highspeed_sys_clock),
		.sel_b   (source_select_r && main_select_r),
		.clk_out (main_clk)
	);

	scsc_clk_mux u_periph_mux (
		.hresetn (hresetn),
		.clk_a   (iosc_clk),
		.clk_b   (highspeed_sys_clock),
		.sel_b   (source_select_r),
		.clk_out (periph_clk)
	);

	scsc_clk_div #(
		.CNT_W (4)
	) u_cpu_div (
		.clk_in  (main_clk),
		.hresetn (hresetn),
		.ratio   (cpu_div_r),
		.clk_out (cpu_clk)
	);
endmodule : scsc_clock_ctrl

// ===== scsc_defs.svh
// Register offsets, field positions, reset values and timing counts of the clock select control.
`ifndef SCSC_DEFS_SVH
`define SCSC_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SCSC_PIN_MODE_OFS   12'h000
`define SCSC_HS_OSC_OFS     12'h004
`define SCSC_MAIN_SEL_OFS   12'h008
`define SCSC_CPU_DIV_OFS    12'h00C
`define SCSC_INT_OSC_OFS    12'h010
`define SCSC_STAB_OFS       12'h014
`define SCSC_STANDBY_OFS    12'h018

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SCSC_EXT_SEL_BIT    7
`define SCSC_PIN_FUNC_BIT   6
`define SCSC_HS_STOP_BIT    7
`define SCSC_SRC_SEL_BIT    2
`define SCSC_SRC_STAT_BIT   1
`define SCSC_MAIN_SEL_BIT   0
`define SCSC_LOW_STAT_BIT   4
`define SCSC_IOSC_STOP_BIT  0
`define SCSC_IOSC_OK_BIT    7
`define SCSC_STOP_CMD_BIT   0

// ----------------------------------------------------------------------
// Reset values, limits and timing
// ----------------------------------------------------------------------
`define SCSC_CPU_DIV_RST    3'h1
`define SCSC_CPU_DIV_MAX    3'h4
`define SCSC_STAB_SEL_RST   3'h5
`define SCSC_HCLK_MHZ       100
`define SCSC_IOSC_SETTLE_US 10
`define SCSC_IOSC_SETTLE_CYC (`SCSC_IOSC_SETTLE_US * `SCSC_HCLK_MHZ)

`endif

// ===== scsc_pkg.sv
// Types shared by the clock select control modules.
package scsc_pkg;
	typedef enum logic [1:0] {
		SCSC_PINS_PORT  = 2'b00,
		SCSC_PINS_XTAL  = 2'b01,
		SCSC_PINS_EXTIN = 2'b10
	} scsc_pin_mode_e;
endpackage : scsc_pkg

// ===== scsc_clk_mux.sv
// Glitch-free two-input clock multiplexer with handshaken enables.
`timescale 1ns/1ps
module scsc_clk_mux (
	input  wire logic hresetn,
	input  wire logic clk_a,
	input  wire logic clk_b,
	input  wire logic sel_b,
	output logic      clk_out
);
	logic a_s1_r;
	logic a_en_r;
	logic b_s1_r;
	logic b_en_r;

	// ----------------------------------------------------------------------
	// Enable synchronisers; each side waits for the other to drop.
	// ----------------------------------------------------------------------
	// Enables change only on the falling edge, while their clock is low, so no runt leaves.
	always_ff @(posedge clk_a or negedge hresetn) begin
		if (!hresetn) begin
			a_s1_r <= 1'b1;
		end else begin
			a_s1_r <= !sel_b && !b_en_r;
		end
	end

	always_ff @(negedge clk_a or negedge hresetn) begin
		if (!hresetn) begin
			a_en_r <= 1'b1;
		end else begin
			a_en_r <= a_s1_r;
		end
	end

	always_ff @(posedge clk_b or negedge hresetn) begin
		if (!hresetn) begin
			b_s1_r <= 1'b0;
		end else begin
			b_s1_r <= sel_b && !a_en_r;
		end
	end

	always_ff @(negedge clk_b or negedge hresetn) begin
		if (!hresetn) begin
			b_en_r <= 1'b0;
		end else begin
			b_en_r <= b_s1_r;
		end
	end

	assign clk_out = (clk_a & a_en_r) | (clk_b & b_en_r);
endmodule : scsc_clk_mux

// ===== scsc_clk_div.sv
// Glitch-free power-of-two clock divider with ratio changed only at a common low phase.
`timescale 1ns/1ps
`include "scsc_defs.svh"
module scsc_clk_div #(
	parameter int CNT_W = 4
) (
	input  wire logic       clk_in,
	input  wire logic       hresetn,
	input  wire logic [2:0] ratio,
	output logic            clk_out
);
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [2:0]       ratio_r;
	logic [2:0]       ratio_nxt;
	logic             div_r;
	logic             div_nxt;
	logic             en_neg_r;

	if (CNT_W < 4) begin : g_cnt_w_check
		$error("scsc_clk_div needs CNT_W of at least 4");
	end

	// ----------------------------------------------------------------------
	// Counter advances every cycle; ratio updates at counter wrap only.
	// ----------------------------------------------------------------------
	always_comb begin
		cnt_nxt   = cnt_r + 1'b1;
		ratio_nxt = ratio_r;
		if (cnt_nxt == '0) begin
			ratio_nxt = ratio;
		end
		div_nxt = 1'b0;
		// The divided clock is high from the wrap on, so a ratio change starts with a full high phase.
		unique case (ratio_nxt)
			3'h0: div_nxt = 1'b1;
			3'h1: div_nxt = !cnt_nxt[0];
			3'h2: div_nxt = !cnt_nxt[1];
			3'h3: div_nxt = !cnt_nxt[2];
			3'h4: div_nxt = !cnt_nxt[3];
			default: div_nxt = !cnt_nxt[0];
		endcase
	end

	always_ff @(posedge clk_in or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r   <= '0;
			ratio_r <= `SCSC_CPU_DIV_RST;
			div_r   <= 1'b0;
		end else begin
			cnt_r   <= cnt_nxt;
			ratio_r <= ratio_nxt;
			div_r   <= div_nxt;
		end
	end

	always_ff @(negedge clk_in or negedge hresetn) begin
		if (!hresetn) begin
			en_neg_r <= 1'b0;
		end else begin
			en_neg_r <= div_r;
		end
	end

	assign clk_out = (ratio_r == 3'h0) ? (clk_in & en_neg_r) : div_r;
endmodule : scsc_clk_div

// ===== scsc_hs_source.sv
// Behavioural crystal or external clock source on the far side of the clock select control.
`timescale 1ns/1ps
module scsc_hs_source #(
	parameter realtime HALF = 6.0
) (
	input  wire logic xtal_osc_enable,
	input  wire logic ext_clk_enable,
	output logic      highspeed_sys_clock
);
	// ----------------------------------------------------------------------
	// Source oscillation
	// ----------------------------------------------------------------------
	initial highspeed_sys_clock = 1'b0;

	// The clock stands low whenever the device has not enabled the source.
	always begin
		#HALF;
		highspeed_sys_clock = (xtal_osc_enable || ext_clk_enable) ? ~highspeed_sys_clock : 1'b0;
	end
endmodule : scsc_hs_source

// ===== scsc_clock_ctrl_asserts.sv
// Concurrent checks on the ports of the clock select control.
`timescale 1ns/1ps
`include "scsc_defs.svh"
module scsc_clock_ctrl_asserts #(
	parameter int SETTLE_CYC = 8
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        wakeup,
	input wire logic        xtal_osc_enable,
	input wire logic        ext_clk_enable,
	input wire logic        crystal_pin_a_port_en,
	input wire logic        crystal_pin_b_port_en,
	input wire logic        iosc_enable,
	input wire logic        stop_mode
);
	// ----------------------------------------------------------------------
	// Write tracking and properties
	// ----------------------------------------------------------------------
	logic take;
	logic wr_hs_r, wr_io_r, wr_sb_r;
	logic wr_hs_nxt, wr_io_nxt, wr_sb_nxt;

	assign take = hsel && hready && htrans[1] && hwrite;

	always_comb begin
		wr_hs_nxt = take && (haddr == `SCSC_HS_OSC_OFS);
		wr_io_nxt = take && (haddr == `SCSC_INT_OSC_OFS);
		wr_sb_nxt = take && (haddr == `SCSC_STANDBY_OFS);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{wr_hs_r, wr_io_r, wr_sb_r} <= 3'h0;
		end else begin
			{wr_hs_r, wr_io_r, wr_sb_r} <= {wr_hs_nxt, wr_io_nxt, wr_sb_nxt};
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	pins_reset_a: assert property ($rose(hresetn) |-> crystal_pin_a_port_en && crystal_pin_b_port_en)
		else $error("pins not in port mode after reset");
	iosc_reset_a: assert property ($rose(hresetn) |-> iosc_enable && !stop_mode)
		else $error("internal oscillator not running after reset");
	xtal_pins_a: assert property (xtal_osc_enable |-> !crystal_pin_a_port_en && !crystal_pin_b_port_en)
		else $error("crystal running with a pin in port mode");
	ext_pins_a: assert property (ext_clk_enable |-> crystal_pin_a_port_en && !crystal_pin_b_port_en && !xtal_osc_enable)
		else $error("external input pins wrong");
	hs_start_a: assert property (wr_hs_r && !hwdata[7] && !crystal_pin_b_port_en && !stop_mode |=>
		(crystal_pin_a_port_en ? ext_clk_enable : xtal_osc_enable)) else $error("source not started");
	hs_stop_a: assert property (wr_hs_r && hwdata[7] |-> ##1 (!xtal_osc_enable && !ext_clk_enable)[*2])
		else $error("source not stopped");
	stop_halt_a: assert property (stop_mode |-> !xtal_osc_enable && !ext_clk_enable)
		else $error("source running in stop mode");
	stop_enter_a: assert property (wr_sb_r && hwdata[0] && !wakeup |=> stop_mode)
		else $error("stop mode not entered");
	iosc_stop_a: assert property (wr_io_r && hwdata[0] |=> !iosc_enable)
		else $error("internal oscillator not stopped");
	iosc_run_a: assert property (wr_io_r && !hwdata[0] && !stop_mode |=> iosc_enable)
		else $error("internal oscillator not restarted");

	cover property (xtal_osc_enable);
	cover property (ext_clk_enable);
	cover property ($rose(stop_mode));
endmodule : scsc_clock_ctrl_asserts

bind scsc_clock_ctrl scsc_clock_ctrl_asserts #(.SETTLE_CYC(SETTLE_CYC)) u_scsc_clock_ctrl_asserts (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .wakeup(wakeup),
	.xtal_osc_enable(xtal_osc_enable), .ext_clk_enable(ext_clk_enable),
	.crystal_pin_a_port_en(crystal_pin_a_port_en), .crystal_pin_b_port_en(crystal_pin_b_port_en),
	.iosc_enable(iosc_enable), .stop_mode(stop_mode));

// ===== system_clock_select_control_bench.sv
// Self-checking bench for the clock select control.
`timescale 1ns/1ps
`include "scsc_defs.svh"
module system_clock_select_control_bench;
	// ----------------------------------------------------------------------
	// Signals, clocks and instances
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic [11:0] a;
		logic [7:0]  wd;
		logic [7:0]  mk;
		logic [7:0]  ex;
		logic [3:0]  o;
	} scsc_row_s;
	localparam scsc_row_s ROWS [10] = '{'{12'h000, 8'h40, 8'hC0, 8'h40, 4'h0},
		'{12'h004, 8'h00, 8'h80, 8'h00, 4'h2}, '{12'h004, 8'h80, 8'h80, 8'h80, 4'h0},
		'{12'h000, 8'hC0, 8'hC0, 8'hC0, 4'h8}, '{12'h004, 8'h00, 8'h80, 8'h00, 4'h9},
		'{12'h004, 8'h80, 8'h80, 8'h80, 4'h8}, '{12'h000, 8'h00, 8'hC0, 8'h00, 4'hC},
		'{12'h000, 8'h40, 8'hC0, 8'h40, 4'h0}, '{12'h004, 8'h00, 8'h80, 8'h00, 4'h2},
		'{12'h014, 8'h03, 8'h07, 8'h03, 4'h2}};
	localparam logic [2:0] SELS [4] = '{3'h0, 3'h1, 3'h4, 3'h5};
	logic        hclk, hresetn, hsel, hwrite, hready, wakeup, cpu_low_status, iosc_clk;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize, stab_sel;
	logic [31:0] hwdata, hrdata, rd;
	logic        hreadyout, hresp, hs_clk, xtal_en, ext_en, pin_a, pin_b, iosc_en, stop_m;
	logic        main_clk, periph_clk, cpu_clk;
	wire  [2:0]  clks = {cpu_clk, periph_clk, main_clk};
	int          n_fail = 0, compares = 0, cycles = 0, p;
	realtime     t_m = 0, t_c = 0, min_w = 1000.0;

	assign hready = hreadyout;
	initial hclk = 1'b0;
	always #5 hclk = ~hclk;
	initial iosc_clk = 1'b0;
	always #10 iosc_clk = iosc_en ? ~iosc_clk : 1'b0;

	scsc_clock_ctrl #(.SETTLE_CYC(8)) u_scsc_clock_ctrl (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .iosc_clk(iosc_clk), .highspeed_sys_clock(hs_clk), .wakeup(wakeup),
		.cpu_low_status(cpu_low_status), .xtal_osc_enable(xtal_en), .ext_clk_enable(ext_en),
		.crystal_pin_a_port_en(pin_a), .crystal_pin_b_port_en(pin_b), .iosc_enable(iosc_en),
		.stop_mode(stop_m), .stabilization_time_select(stab_sel), .main_clk(main_clk),
		.periph_clk(periph_clk), .cpu_clk(cpu_clk));
	scsc_hs_source u_scsc_hs_source (.xtal_osc_enable(xtal_en), .ext_clk_enable(ext_en),
		.highspeed_sys_clock(hs_clk));

	// Shortest pulse seen on the main and CPU clocks.
	always @(main_clk) begin
		if (hresetn === 1'b1 && $realtime - t_m < min_w) min_w = $realtime - t_m;
		t_m = $realtime;
	end
	always @(cpu_clk) begin
		if (hresetn === 1'b1 && $realtime - t_c < min_w) min_w = $realtime - t_c;
		t_c = $realtime;
	end
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	// ----------------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish();
		if (n_fail == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'b10;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : xfer

	task automatic period(input int i, output int ns);
		realtime t0;
		@(posedge clks[i]);
		@(posedge clks[i]);
		t0 = $realtime;
		@(posedge clks[i]);
		ns = int'($realtime - t0);
	endtask : period

	// ----------------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------------
	initial begin
		{hresetn, hsel, hwrite, wakeup, cpu_low_status, haddr, htrans, hwdata} = '0;
		hsize = 3'h2;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		// Pin modes are changed only while the source is stopped.
		foreach (ROWS[i]) begin
			xfer(ROWS[i].a, 1'b1, 32'(ROWS[i].wd));
			xfer(ROWS[i].a, 1'b0, 32'h0);
			check(rd & 32'(ROWS[i].mk), 32'(ROWS[i].ex));
			check(32'({pin_a, pin_b, xtal_en, ext_en}), 32'(ROWS[i].o));
		end
		repeat (20) @(posedge hclk);
		foreach (SELS[i]) begin
			xfer(`SCSC_MAIN_SEL_OFS, 1'b1, 32'(SELS[i]));
			repeat (20) @(posedge hclk);
			xfer(`SCSC_MAIN_SEL_OFS, 1'b0, 32'h0);
			check(rd & 32'h7, 32'(SELS[i] | ((SELS[i] == 3'h5) ? 3'h2 : 3'h0)));
			period(0, p);
			check(32'(p), (SELS[i] == 3'h5) ? 32'd12 : 32'd20);
			period(1, p);
			check(32'(p), SELS[i][2] ? 32'd12 : 32'd20);
		end
		for (int k = 0; k < 5; k++) begin
			xfer(`SCSC_CPU_DIV_OFS, 1'b1, 32'(k));
			repeat (40) @(posedge hclk);
			period(2, p);
			check(32'(p), 32'(12 << k));
		end
		xfer(`SCSC_CPU_DIV_OFS, 1'b1, 32'h7);
		cpu_low_status <= 1'b1;
		xfer(`SCSC_CPU_DIV_OFS, 1'b0, 32'h0);
		check(rd & 32'h17, 32'h14);
		xfer(`SCSC_INT_OSC_OFS, 1'b1, 32'h1);
		@(negedge hclk);
		check(32'(iosc_en), 32'h0);
		xfer(`SCSC_INT_OSC_OFS, 1'b1, 32'h0);
		@(negedge hclk);
		check(32'(iosc_en), 32'h1);
		xfer(`SCSC_INT_OSC_OFS, 1'b0, 32'h0);
		check(rd & 32'h80, 32'h0);
		repeat (12) @(posedge hclk);
		xfer(`SCSC_INT_OSC_OFS, 1'b0, 32'h0);
		check(rd & 32'h81, 32'h80);
		xfer(`SCSC_MAIN_SEL_OFS, 1'b1, 32'h0);
		repeat (20) @(posedge hclk);
		xfer(`SCSC_MAIN_SEL_OFS, 1'b0, 32'h0);
		check(rd & 32'h2, 32'h0);
		check(32'(stab_sel), 32'h3);
		xfer(`SCSC_STANDBY_OFS, 1'b1, 32'h1);
		@(negedge hclk);
		check(32'({stop_m, xtal_en}), 32'h2);
		@(posedge hclk);
		wakeup <= 1'b1;
		repeat (2) @(posedge hclk);
		wakeup <= 1'b0;
		check(32'(stop_m), 32'h0);
		xfer(`SCSC_HS_OSC_OFS, 1'b1, 32'h80);
		@(negedge hclk);
		check(32'(xtal_en), 32'h0);
		xfer(12'h020, 1'b1, 32'hFFFFFFFF);
		xfer(12'h020, 1'b0, 32'h0);
		check(rd, 32'h0);
		check(32'({hreadyout, hresp}), 32'h2);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		check(32'({pin_a, pin_b, xtal_en, ext_en, iosc_en, stop_m}), 32'h32);
		xfer(`SCSC_CPU_DIV_OFS, 1'b0, 32'h0);
		check(rd & 32'h7, 32'h1);
		xfer(`SCSC_MAIN_SEL_OFS, 1'b0, 32'h0);
		check(rd & 32'h7, 32'h0);
		period(2, p);
		check(32'(p), 32'd40);
		check(32'(min_w >= 5.9), 32'h1);
		tally_and_finish();
	end
endmodule : system_clock_select_control_bench
